// >>> common/tss_pkg.sv
// package of constants for the temperature sensor sequencer
package tss_pkg;

  // ---------------------------------------------------------------
  // register byte addresses (printed offsets are not word aligned)
  // ---------------------------------------------------------------
  localparam logic [15:0] TSS_IDX_RESULT_HIGH = 16'h2881;
  localparam logic [15:0] TSS_IDX_RESULT_LOW  = 16'h2882;
  localparam logic [15:0] TSS_IDX_CTRL        = 16'h28A0;
  localparam logic [15:0] TSS_IDX_TRIGGER     = 16'h28B4;
  localparam logic [15:0] TSS_IDX_MODE        = 16'h28B5;
  localparam logic [15:0] TSS_IDX_BATTERY     = 16'h28B6;
  localparam int          TSS_ADDR_W          = 18;
  localparam logic [17:0] TSS_ADDR_RESULT_HIGH = {TSS_IDX_RESULT_HIGH, 2'b00};
  localparam logic [17:0] TSS_ADDR_RESULT_LOW  = {TSS_IDX_RESULT_LOW, 2'b00};
  localparam logic [17:0] TSS_ADDR_CTRL        = {TSS_IDX_CTRL, 2'b00};
  localparam logic [17:0] TSS_ADDR_TRIGGER     = {TSS_IDX_TRIGGER, 2'b00};
  localparam logic [17:0] TSS_ADDR_MODE        = {TSS_IDX_MODE, 2'b00};
  localparam logic [17:0] TSS_ADDR_BATTERY     = {TSS_IDX_BATTERY, 2'b00};

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int TSS_CTRL_PER_LSB   = 0;
  localparam int TSS_CTRL_BUSY_BIT  = 3;
  localparam int TSS_CTRL_BAT_BIT   = 4;
  localparam int TSS_CTRL_PWR_BIT   = 6;
  localparam int TSS_CTRL_BSEL_BIT  = 7;
  localparam int TSS_TRIG_BIT       = 6;
  localparam int TSS_LOW_LSB        = 5;

  // ---------------------------------------------------------------
  // reset values and codes
  // ---------------------------------------------------------------
  localparam logic [7:0]  TSS_CTRL_RESET   = 8'h00;
  localparam logic [2:0]  TSS_PER_MANUAL   = 3'h0;
  localparam logic [2:0]  TSS_PER_CONT     = 3'h7;
  localparam logic [3:0]  TSS_PER_EXP_BASE = 4'h3;
  localparam logic [1:0]  TSS_RESP_OKAY    = 2'h0;
  localparam logic [1:0]  TSS_RESP_SLVERR  = 2'h2;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int TSS_CLK_HZ        = 125000000;
  localparam int TSS_SEC_NS        = 1000000000;
  localparam int TSS_CLK_NS        = 8;
  localparam int TSS_SEC_CYCLES    = TSS_SEC_NS / TSS_CLK_NS;
  localparam int TSS_BUSY_US       = 6;
  localparam int TSS_BUSY_CYCLES   = (TSS_BUSY_US * 1000 + TSS_CLK_NS - 1) / TSS_CLK_NS;

  typedef enum logic [1:0] {
    TSS_MODE_MAINS   = 2'b00,
    TSS_MODE_BROWN   = 2'b01,
    TSS_MODE_DISPLAY = 2'b10,
    TSS_MODE_SLEEP   = 2'b11
  } tss_mode_type;

  typedef enum logic [1:0] {
    TSS_ST_IDLE = 2'b00,
    TSS_ST_TEMP = 2'b01,
    TSS_ST_BATT = 2'b10
  } tss_state_type;

endpackage

// >>> rtl/tss_sequencer.sv
// temperature sensor sequencer with axi4-lite register slave
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module tss_sequencer #(
  parameter int SEC_CYCLES  = tss_pkg::TSS_SEC_CYCLES,
  parameter int BUSY_CYCLES = tss_pkg::TSS_BUSY_CYCLES
) (
  // clock and reset
  input  wire logic                          i_mclk,
  input  wire logic                          i_rst,
  // axi4-lite write address and data
  input  wire logic [tss_pkg::TSS_ADDR_W-1:0] i_awaddr,
  input  wire logic                          i_awvalid,
  output logic                               o_awready,
  input  wire logic [31:0]                   i_wdata,
  input  wire logic [3:0]                    i_wstrb,
  input  wire logic                          i_wvalid,
  output logic                               o_wready,
  output logic [1:0]                         o_bresp,
  output logic                               o_bvalid,
  input  wire logic                          i_bready,
  // axi4-lite read
  input  wire logic [tss_pkg::TSS_ADDR_W-1:0] i_araddr,
  input  wire logic                          i_arvalid,
  output logic                               o_arready,
  output logic [31:0]                        o_rdata,
  output logic [1:0]                         o_rresp,
  output logic                               o_rvalid,
  input  wire logic                          i_rready,
  // operating mode from power manager
  input  wire tss_pkg::tss_mode_type         i_mode,
  // analog sensing element
  output logic                               o_sense_start,
  output logic                               o_sense_battery,
  output logic                               o_sensor_supply_select,
  output logic                               o_monitored_battery_select,
  input  wire logic                          i_sense_done,
  input  wire logic [10:0]                   i_sensed_temp_value,
  input  wire logic [7:0]                    i_battery_voltage_reading
);
  import tss_pkg::*;

  // ---------------------------------------------------------------
  // synchronisers for the analog side and the power manager mode
  // ---------------------------------------------------------------
  logic       done_meta;
  logic       done_sync;
  logic       done_prev;
  logic       done_rise;
  logic [1:0] mode_meta;
  logic [1:0] mode_sync;

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      done_meta <= 1'b0;
      done_sync <= 1'b0;
      done_prev <= 1'b0;
      mode_meta <= 2'h0;
      mode_sync <= 2'h0;
    end else begin
      done_meta <= i_sense_done;
      done_sync <= done_meta;
      done_prev <= done_sync;
      mode_meta <= i_mode;
      mode_sync <= mode_meta;
    end
  end
  assign done_rise = done_sync & ~done_prev;

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [2:0]  temp_period_select;
  logic        battery_measure_with_temp;
  logic        sensor_supply_select;
  logic        monitored_battery_select;
  logic        ctrl_byte_write_pending;
  logic [15:0] busy_cnt;
  logic        temp_measure_trigger;
  logic [10:0] sensed_temp_value;
  logic [7:0]  battery_voltage_reading;
  logic        low_power;
  logic        wr_fire;
  logic        aw_held;
  logic        w_held;
  logic [TSS_ADDR_W-1:0] aw_addr;
  logic [7:0]  w_byte;
  logic        w_lane0;
  tss_state_type state;
  logic        period_tick;
  logic        temp_done;

  assign low_power = (mode_sync == TSS_MODE_SLEEP) || (mode_sync == TSS_MODE_DISPLAY);

  // ---------------------------------------------------------------
  // axi4-lite write channel
  // ---------------------------------------------------------------
  assign o_awready = ~aw_held & ~o_bvalid;
  assign o_wready  = ~w_held & ~o_bvalid;
  assign wr_fire   = aw_held & w_held & ~o_bvalid;

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= '0;
      w_byte  <= 8'h00;
      w_lane0 <= 1'b0;
      o_bvalid <= 1'b0;
      o_bresp  <= TSS_RESP_OKAY;
    end else begin
      if (i_awvalid && o_awready) begin
        aw_held <= 1'b1;
        aw_addr <= i_awaddr;
      end
      if (i_wvalid && o_wready) begin
        w_held  <= 1'b1;
        w_byte  <= i_wdata[7:0];
        w_lane0 <= i_wstrb[0];
      end
      if (wr_fire) begin
        aw_held  <= 1'b0;
        w_held   <= 1'b0;
        o_bvalid <= 1'b1;
        case (aw_addr)
          TSS_ADDR_CTRL, TSS_ADDR_TRIGGER, TSS_ADDR_RESULT_HIGH, TSS_ADDR_RESULT_LOW,
          TSS_ADDR_MODE, TSS_ADDR_BATTERY: o_bresp <= TSS_RESP_OKAY;
          default: o_bresp <= TSS_RESP_SLVERR;
        endcase
      end else if (o_bvalid && i_bready) begin
        o_bvalid <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // control byte with write-pending lockout
  // ---------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      temp_period_select        <= TSS_CTRL_RESET[2:0];
      battery_measure_with_temp <= 1'b0;
      sensor_supply_select      <= 1'b0;
      monitored_battery_select  <= 1'b0;
      ctrl_byte_write_pending   <= 1'b0;
      busy_cnt                  <= 16'h0000;
    end else if (wr_fire && w_lane0 && aw_addr == TSS_ADDR_CTRL
                 && !ctrl_byte_write_pending) begin
      temp_period_select        <= w_byte[TSS_CTRL_PER_LSB +: 3];
      battery_measure_with_temp <= w_byte[TSS_CTRL_BAT_BIT];
      sensor_supply_select      <= w_byte[TSS_CTRL_PWR_BIT];
      monitored_battery_select  <= w_byte[TSS_CTRL_BSEL_BIT];
      ctrl_byte_write_pending   <= 1'b1;
      busy_cnt                  <= BUSY_CYCLES[15:0];
    end else if (ctrl_byte_write_pending) begin
      busy_cnt <= busy_cnt - 16'h0001;
      if (busy_cnt == 16'h0001) begin
        ctrl_byte_write_pending <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // trigger bit: set by software, cleared by hardware at completion
  // ---------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      temp_measure_trigger <= 1'b0;
    end else if (wr_fire && w_lane0 && aw_addr == TSS_ADDR_TRIGGER
                 && w_byte[TSS_TRIG_BIT]) begin
      temp_measure_trigger <= 1'b1;
    end else if (temp_done) begin
      temp_measure_trigger <= 1'b0;
    end else if (wr_fire && w_lane0 && aw_addr == TSS_ADDR_TRIGGER) begin
      temp_measure_trigger <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // period timer: seconds prescaler and interval counter
  // ---------------------------------------------------------------
  logic [31:0] sec_cnt;
  logic [9:0]  secs;
  logic [9:0]  interval;

  assign interval = 10'h001 << (TSS_PER_EXP_BASE + {1'b0, temp_period_select});

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      sec_cnt     <= 32'h0000_0000;
      secs        <= 10'h000;
      period_tick <= 1'b0;
    end else begin
      period_tick <= 1'b0;
      if (temp_period_select == TSS_PER_MANUAL || temp_period_select == TSS_PER_CONT) begin
        sec_cnt <= 32'h0000_0000;
        secs    <= 10'h000;
      end else if (sec_cnt == SEC_CYCLES - 1) begin
        sec_cnt <= 32'h0000_0000;
        if (secs + 10'h001 >= interval) begin
          secs        <= 10'h000;
          period_tick <= 1'b1;
        end else begin
          secs <= secs + 10'h001;
        end
      end else begin
        sec_cnt <= sec_cnt + 32'h0000_0001;
      end
    end
  end

  // ---------------------------------------------------------------
  // measurement sequencer
  // ---------------------------------------------------------------
  logic start_req;
  logic manual_go;
  logic auto_go;

  assign manual_go = temp_measure_trigger && temp_period_select == TSS_PER_MANUAL
                     && !low_power;
  assign auto_go   = low_power && (period_tick
                     || temp_period_select == TSS_PER_CONT);
  assign start_req = manual_go || auto_go;
  assign temp_done = done_rise && state == TSS_ST_TEMP;

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      state                   <= TSS_ST_IDLE;
      o_sense_start           <= 1'b0;
      o_sense_battery         <= 1'b0;
      sensed_temp_value       <= 11'h000;
      battery_voltage_reading <= 8'h00;
    end else begin
      o_sense_start <= 1'b0;
      unique case (state)
        TSS_ST_IDLE: begin
          if (start_req) begin
            state           <= TSS_ST_TEMP;
            o_sense_start   <= 1'b1;
            o_sense_battery <= 1'b0;
          end
        end
        TSS_ST_TEMP: begin
          if (done_rise) begin
            sensed_temp_value <= i_sensed_temp_value;
            if (battery_measure_with_temp) begin
              state           <= TSS_ST_BATT;
              o_sense_start   <= 1'b1;
              o_sense_battery <= 1'b1;
            end else begin
              state <= TSS_ST_IDLE;
            end
          end
        end
        TSS_ST_BATT: begin
          if (done_rise) begin
            battery_voltage_reading <= i_battery_voltage_reading;
            o_sense_battery         <= 1'b0;
            state                   <= TSS_ST_IDLE;
          end
        end
        default: state <= TSS_ST_IDLE;
      endcase
    end
  end

  // supply routing to the analog element
  assign o_sensor_supply_select     = sensor_supply_select & ~low_power;
  assign o_monitored_battery_select = monitored_battery_select;

  // ---------------------------------------------------------------
  // axi4-lite read channel
  // ---------------------------------------------------------------
  assign o_arready = ~o_rvalid;

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_rvalid <= 1'b0;
      o_rdata  <= 32'h0000_0000;
      o_rresp  <= TSS_RESP_OKAY;
    end else if (i_arvalid && o_arready) begin
      o_rvalid <= 1'b1;
      o_rresp  <= TSS_RESP_OKAY;
      case (i_araddr)
        TSS_ADDR_RESULT_HIGH: o_rdata <= {24'h000000, sensed_temp_value[10:3]};
        TSS_ADDR_RESULT_LOW:  o_rdata <= {24'h000000, sensed_temp_value[2:0], 5'h00};
        TSS_ADDR_CTRL: o_rdata <= {24'h000000, monitored_battery_select, sensor_supply_select,
                                   1'b0, battery_measure_with_temp, ctrl_byte_write_pending,
                                   temp_period_select};
        TSS_ADDR_TRIGGER: o_rdata <= {24'h000000, 1'b0, temp_measure_trigger, 6'h00};
        TSS_ADDR_MODE:    o_rdata <= {30'h0000_0000, mode_sync};
        TSS_ADDR_BATTERY: o_rdata <= {24'h000000, battery_voltage_reading};
        default: begin
          o_rdata <= 32'h0000_0000;
          o_rresp <= TSS_RESP_SLVERR;
        end
      endcase
    end else if (o_rvalid && i_rready) begin
      o_rvalid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  AST_BUSY_LOCK: assert property (@(posedge i_mclk) disable iff (i_rst)
    ctrl_byte_write_pending && wr_fire |=> $stable(temp_period_select))
    else $error("control byte changed while write pending");
  AST_BUSY_SET: assert property (@(posedge i_mclk) disable iff (i_rst)
    wr_fire && w_lane0 && aw_addr == TSS_ADDR_CTRL && !ctrl_byte_write_pending
    |=> ctrl_byte_write_pending)
    else $error("pending flag not set after control write");
  AST_MANUAL_ONLY: assert property (@(posedge i_mclk) disable iff (i_rst)
    $rose(o_sense_start) && !o_sense_battery && !low_power
    |-> $past(temp_measure_trigger))
    else $error("measurement started without trigger in active mode");
  AST_TRIG_PER: assert property (@(posedge i_mclk) disable iff (i_rst)
    state == TSS_ST_IDLE && temp_measure_trigger && temp_period_select != TSS_PER_MANUAL
    && !low_power |=> state == TSS_ST_IDLE)
    else $error("trigger acted with nonzero period");
  AST_TRIG_CLR: assert property (@(posedge i_mclk) disable iff (i_rst)
    temp_done |=> !temp_measure_trigger)
    else $error("trigger not cleared at completion");
  AST_RESULT: assert property (@(posedge i_mclk) disable iff (i_rst)
    temp_done |=> sensed_temp_value == $past(i_sensed_temp_value))
    else $error("result not captured at completion");
  AST_BATT: assert property (@(posedge i_mclk) disable iff (i_rst)
    temp_done && battery_measure_with_temp |=> state == TSS_ST_BATT && o_sense_battery)
    else $error("battery measurement skipped");
  AST_SUPPLY: assert property (@(posedge i_mclk) disable iff (i_rst)
    low_power |-> !o_sensor_supply_select)
    else $error("main supply used in low power mode");
  AST_CONT: assert property (@(posedge i_mclk) disable iff (i_rst)
    low_power && temp_period_select == TSS_PER_CONT && state == TSS_ST_IDLE
    |=> state == TSS_ST_TEMP)
    else $error("continuous mode did not restart");
  COV_MANUAL: cover property (@(posedge i_mclk) manual_go && state == TSS_ST_IDLE);
  COV_PERIODIC: cover property (@(posedge i_mclk) period_tick && low_power);
  COV_BATT: cover property (@(posedge i_mclk) state == TSS_ST_BATT && done_rise);
  COV_LOCKED: cover property (@(posedge i_mclk) ctrl_byte_write_pending && wr_fire);

endmodule

// >>> tb/test_temp_sensor_sequencer.sv
// self-checking testbench of the temperature sensor sequencer
`timescale 1ns/100ps
module test_temp_sensor_sequencer;
  import tss_pkg::*;
  localparam int SEC = 10;
  logic i_mclk, i_rst, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready, slow, flat;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, i_sense_done;
  logic o_sense_start, o_sense_battery, o_sensor_supply_select, o_monitored_battery_select;
  logic [17:0] i_awaddr, i_araddr;
  logic [31:0] i_wdata, o_rdata, rd;
  logic [3:0] i_wstrb;
  logic [1:0] o_bresp, o_rresp, rr;
  logic [10:0] i_sensed_temp_value, last_temp;
  logic [7:0] i_battery_voltage_reading, last_batt;
  tss_mode_type i_mode;
  int num_errors = 0, n_tests = 0, n_start = 0, cyc = 0;
  int t_start[$];

  tss_sequencer #(.SEC_CYCLES(SEC), .BUSY_CYCLES(20)) dut_u (.*);
  tss_sense_model sense_u (.i_mclk(i_mclk), .i_slow(slow), .i_start(o_sense_start),
    .i_battery(o_sense_battery), .i_supply_main(o_sensor_supply_select), .i_flat(flat),
    .o_done(i_sense_done), .o_temp(i_sensed_temp_value),
    .o_batt(i_battery_voltage_reading), .o_last_temp(last_temp), .o_last_batt(last_batt));

  initial begin
    i_mclk = 1'b0;
    forever #4 i_mclk = ~i_mclk;
  end

  always @(posedge i_mclk) begin
    cyc++;
    if (o_sense_start === 1'b1) begin
      n_start++;
      t_start.push_back(cyc);
    end
  end

  // ---------------------------------------------------------------
  // checks and bus tasks
  // ---------------------------------------------------------------
  task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      num_errors++;
    end
  endtask

  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("wrong value at %0t: resp %h expected %h", $time, got, exp);
      num_errors++;
    end
  endtask

  task automatic stop_test();
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic axw(input logic [17:0] a, input logic [7:0] d, output logic [1:0] r);
    int n;
    logic aw_go, w_go, b_go;
    n = 0;
    @(posedge i_mclk);
    i_awaddr <= a;
    i_wdata <= {24'($urandom), d};
    i_wstrb <= 4'hF;
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    i_bready <= 1'b1;
    do begin
      // look at settled handshakes, act after the edge that takes them
      @(negedge i_mclk);
      aw_go = i_awvalid && (o_awready === 1'b1);
      w_go = i_wvalid && (o_wready === 1'b1);
      b_go = (o_bvalid === 1'b1);
      r = o_bresp;
      @(posedge i_mclk);
      n++;
      if (aw_go) i_awvalid <= 1'b0;
      if (w_go) i_wvalid <= 1'b0;
    end while (!b_go && n < 100);
    i_bready <= 1'b0;
    if (!b_go) num_errors++;
  endtask

  task automatic axr(input logic [17:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    logic ar_go, r_go;
    n = 0;
    @(posedge i_mclk);
    i_araddr <= a;
    i_arvalid <= 1'b1;
    i_rready <= 1'b1;
    do begin
      @(negedge i_mclk);
      ar_go = i_arvalid && (o_arready === 1'b1);
      r_go = (o_rvalid === 1'b1);
      d = o_rdata;
      r = o_rresp;
      @(posedge i_mclk);
      n++;
      if (ar_go) i_arvalid <= 1'b0;
    end while (!r_go && n < 100);
    i_rready <= 1'b0;
    if (!r_go) num_errors++;
  endtask

  task automatic set_ctrl(input logic [7:0] c);
    axw(TSS_ADDR_CTRL, c, rr);
    repeat (25) @(posedge i_mclk);
  endtask

  task automatic set_mode(input tss_mode_type m);
    @(posedge i_mclk);
    i_mode <= m;
    repeat (5) @(posedge i_mclk);
  endtask

  task automatic chk_result();
    logic [31:0] hi;
    axr(TSS_ADDR_RESULT_HIGH, hi, rr);
    axr(TSS_ADDR_RESULT_LOW, rd, rr);
    chk_data({hi[15:0], rd[15:0]}, {8'h0, last_temp[10:3], 8'h0, last_temp[2:0], 5'h0});
  endtask

  task automatic trig(input int n);
    int n0, k;
    n0 = n_start;
    k = 0;
    axw(TSS_ADDR_TRIGGER, 8'h40, rr);
    do begin
      axr(TSS_ADDR_TRIGGER, rd, rr);
      k++;
    end while (rd[6] !== 1'b0 && k < 40);
    if (n > 0) chk_data({31'h0, rd[6]}, 32'h0);
    repeat (80) @(posedge i_mclk);
    chk_data(n_start - n0, n);
    axw(TSS_ADDR_TRIGGER, 8'h00, rr);
  endtask

  task automatic wait_n(input int n, input int lim);
    int k;
    k = 0;
    while (n_start < n && k < lim) begin
      @(posedge i_mclk);
      k++;
    end
    chk_data(32'(n_start >= n), 32'h1);
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    logic [7:0] c;
    int n0;
    i_rst = 1'b1;
    {i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready, slow, flat} = '0;
    i_awaddr = '0;
    i_araddr = '0;
    i_wdata = '0;
    i_wstrb = '0;
    i_mode = TSS_MODE_MAINS;
    void'($urandom(32'h63971013));
    repeat (5) @(posedge i_mclk);
    i_rst <= 1'b0;
    axr(TSS_ADDR_CTRL, rd, rr);
    chk_data(rd, 32'h0);
    axr(18'h00004, rd, rr);
    chk_resp(rr, TSS_RESP_SLVERR);
    axw(18'h00004, 8'hFF, rr);
    chk_resp(rr, TSS_RESP_SLVERR);
    axw(TSS_ADDR_CTRL, 8'hC0, rr);
    chk_resp(rr, TSS_RESP_OKAY);
    axw(TSS_ADDR_CTRL, 8'h17, rr);
    axr(TSS_ADDR_CTRL, rd, rr);
    chk_data(rd, 32'hC8);
    repeat (30) @(posedge i_mclk);
    axr(TSS_ADDR_CTRL, rd, rr);
    chk_data(rd, 32'hC0);
    chk_data({30'h0, o_sensor_supply_select, o_monitored_battery_select}, 32'h3);
    // firmware keeps supply and monitored battery equal
    for (int i = 0; i < 4; i++) begin
      slow <= 1'($urandom);
      c = {{2{1'($urandom)}}, 1'b0, 1'($urandom), 4'h0};
      set_mode(i[0] ? TSS_MODE_BROWN : TSS_MODE_MAINS);
      set_ctrl(c);
      trig(c[4] ? 2 : 1);
      chk_result();
      axr(TSS_ADDR_BATTERY, rd, rr);
      if (c[4]) chk_data(rd, {24'h0, last_batt});
    end
    // flat rtc battery stalls the conversion; firmware moves the sensor to main supply
    set_mode(TSS_MODE_MAINS);
    flat <= 1'b1;
    set_ctrl(8'h00);
    axw(TSS_ADDR_TRIGGER, 8'h40, rr);
    repeat (100) @(posedge i_mclk);
    axr(TSS_ADDR_TRIGGER, rd, rr);
    chk_data(rd, 32'h40);
    set_ctrl(8'h40);
    repeat (120) @(posedge i_mclk);
    axr(TSS_ADDR_TRIGGER, rd, rr);
    chk_data(rd, 32'h0);
    chk_result();
    flat <= 1'b0;
    set_mode(TSS_MODE_MAINS);
    set_ctrl(8'h02);
    trig(0);
    set_mode(TSS_MODE_SLEEP);
    set_ctrl(8'h40);
    trig(0);
    chk_data({31'h0, o_sensor_supply_select}, 32'h0);
    for (int p = 1; p < 7; p++) begin
      set_mode(p[0] ? TSS_MODE_SLEEP : TSS_MODE_DISPLAY);
      n0 = n_start;
      set_ctrl(8'(p));
      wait_n(n0 + 3, (32 * SEC) << p);
      chk_data(t_start[$] - t_start[$-1], (8 * SEC) << p);
      repeat (60) @(posedge i_mclk);
      chk_result();
      set_ctrl(8'h00);
    end
    set_mode(TSS_MODE_DISPLAY);
    slow <= 1'b1;
    n0 = n_start;
    set_ctrl(8'h07);
    wait_n(n0 + 4, 1000);
    chk_data(32'(t_start[$] - t_start[$-1] < 70), 32'h1);
    set_ctrl(8'h00);
    repeat (80) @(posedge i_mclk);
    chk_result();
    stop_test();
  end

  initial begin
    repeat (90000) @(posedge i_mclk);
    num_errors++;
    stop_test();
  end
endmodule

// >>> tb/tss_sense_model.sv
// behavioural model of the analog temperature sensing element and battery monitor
`timescale 1ns/100ps
module tss_sense_model (
  // clock and speed choice
  input  wire logic        i_mclk,
  input  wire logic        i_slow,
  // conversion requests
  input  wire logic        i_start,
  input  wire logic        i_battery,
  // supply routing and a nearly flat rtc battery
  input  wire logic        i_supply_main,
  input  wire logic        i_flat,
  // conversion results
  output logic             o_done,
  output logic [10:0]      o_temp,
  output logic [7:0]       o_batt,
  output logic [10:0]      o_last_temp,
  output logic [7:0]       o_last_batt
);
  int cnt = 0;

  initial begin
    o_done = 1'b0;
    o_temp = 11'h2AA;
    o_batt = 8'h55;
    o_last_temp = 11'h000;
    o_last_batt = 8'h00;
  end

  // one conversion per start pulse, done held four cycles
  always @(posedge i_mclk) begin
    logic [10:0] v;
    v = 11'($urandom);
    if (i_start === 1'b1) begin
      cnt <= i_slow ? 46 : 9;
      if (i_battery === 1'b1) begin
        o_batt <= v[7:0];
        o_last_batt <= v[7:0];
      end else begin
        o_temp <= v;
        o_last_temp <= v;
      end
    end else if (cnt > 0 && !(i_flat && !i_supply_main)) begin
      // a flat rtc battery stalls the conversion until main supply is chosen
      cnt <= cnt - 1;
      // released lines show the inverse so a late sample cannot pass
      if (cnt == 1) begin
        o_temp <= ~o_temp;
        o_batt <= ~o_batt;
      end
    end
    o_done <= (cnt >= 3 && cnt <= 6);
  end
endmodule
